// >>> design/pplm_pkg.sv
// Package for the seconds-pulse relay and link mode control block.
// Assumes a single 50 MHz clock and an Avalon-MM register slave.
package pplm_pkg;

  // Register byte offsets
  localparam logic [4:0] OFF_DELAY = 5'h00;
  localparam logic [4:0] OFF_DIAG = 5'h04;
  localparam logic [4:0] OFF_MODE = 5'h08;
  localparam logic [4:0] OFF_STAT = 5'h0c;
  localparam logic [4:0] OFF_BURST = 5'h10;

  // Mode register field positions
  localparam int MODE_LSB = 0;
  localparam int MODE_RTSCTS_BIT = 2;
  localparam int MODE_MASTER_BIT = 3;

  // Status register field positions
  localparam int STAT_TXOVF_BIT = 0;
  localparam int STAT_RXOVF_BIT = 1;
  localparam int STAT_PPSEN_BIT = 2;
  localparam int STAT_CD_BIT = 3;
  localparam int STAT_BURST_BIT = 4;
  localparam int STAT_TXLVL_LSB = 8;
  localparam int STAT_RXLVL_LSB = 20;

  // Reset values and limits
  localparam logic [7:0] DELAY_RST = 8'hff;
  localparam logic [7:0] DELAY_OFF = 8'hff;
  localparam logic [7:0] DIAG_RST = 8'h00;
  localparam logic [7:0] DIAG_MAX = 8'h81;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [11:0] BURST_RST = 12'h040;

  // Buffers
  localparam int BUF_DEPTH = 2048;
  localparam int BUF_AW = 11;
  localparam int BUF_CW = 12;
  localparam logic [11:0] BUF_FULL = 12'h800;
  localparam logic [11:0] CTS_LIMIT = 12'h7f0;

  // Timing
  localparam int CLK_NS = 20;
  localparam logic [27:0] CLK_PS = 28'(CLK_NS * 1000);
  localparam logic [27:0] STEP_PS = 28'h0084746; // 542534 ps per step
  localparam int PPS_MAX_US = 20;
  localparam int SYNC_SLACK_CYC = 8;
  localparam logic [27:0] PPS_CAP_PS =
    28'(PPS_MAX_US * 1000000 - SYNC_SLACK_CYC * CLK_NS * 1000);
  localparam int CD_HIGH_MS = 2;
  localparam int CD_HIGH_CYC = CD_HIGH_MS * 1000000 / CLK_NS;

  typedef enum logic [1:0] {
    TXM_IMMEDIATE,
    TXM_DTR_LINK,
    TXM_BURST
  } pplm_txmode_t;

  typedef enum logic [1:0] {
    PPS_IDLE,
    PPS_WAIT,
    PPS_HIGH
  } pplm_pps_st_t;

  typedef struct packed {
    logic [7:0] delay;
    logic [7:0] diag;
    logic [1:0] mode;
    logic rts_cts_en;
    logic is_master;
    logic [11:0] burst_thr;
  } pplm_cfg_t;

  localparam pplm_cfg_t CFG_RST = '{delay: DELAY_RST, diag: DIAG_RST,
    mode: MODE_RST, rts_cts_en: 1'b0, is_master: 1'b0,
    burst_thr: BURST_RST};

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    pplm_cfg_t cfg;
    logic tx_ovf;
    logic rx_ovf;
    logic [2:0] dtr_sy;
    logic [2:0] rts_sy;
    logic dtr_f;
    logic rts_f;
    logic prx_prev;
    logic pps_tx;
    pplm_pps_st_t pps_st;
    logic [27:0] rem_ps;
    logic [16:0] hi_cnt;
    logic cd;
    logic bursting;
    logic send_ok;
    logic cts;
    logic [7:0] diag_lvl;
  } pplm_state_t;

  typedef struct packed {
    logic [10:0] wptr;
    logic [10:0] rptr;
    logic [11:0] cnt;
    logic rd_valid;
    logic [7:0] rd_data;
    logic wr_ready;
    logic ovf;
  } pplm_buf_state_t;

endpackage

// >>> design/pplm_buf.sv
// Byte buffer of fixed depth with a registered output stage.
// Assumes writer and reader on the same clock and a synchronous reset copy.
`timescale 1ns/1ps
`default_nettype none
module pplm_buf
  import pplm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  input wire logic rd_en,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  output logic [11:0] level,
  output logic overflow
);

  logic [7:0] mem [BUF_DEPTH];
  pplm_buf_state_t s_q, s_d;
  logic push, pop;

  always_comb begin
    s_d = s_q;
    push = wr_valid && (s_q.cnt != BUF_FULL);
    pop = rd_en && (s_q.cnt != 12'h000) && (!s_q.rd_valid || rd_ready);
    // Write into a full buffer is lost and flagged
    s_d.ovf = wr_valid && (s_q.cnt == BUF_FULL);
    if (push) begin
      s_d.wptr = s_q.wptr + 11'h001;
    end
    if (pop) begin
      s_d.rptr = s_q.rptr + 11'h001;
      s_d.rd_data = mem[s_q.rptr];
      s_d.rd_valid = 1'b1;
    end else if (rd_ready) begin
      s_d.rd_valid = 1'b0;
    end
    s_d.cnt = s_q.cnt + {11'h000, push} - {11'h000, pop};
    s_d.wr_ready = (s_d.cnt != BUF_FULL);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.wr_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_q.wptr] <= wr_data;
    end
  end

  assign wr_ready = s_q.wr_ready;
  assign rd_valid = s_q.rd_valid;
  assign rd_data = s_q.rd_data;
  assign level = s_q.cnt;
  assign overflow = s_q.ovf;

  property p_buf_ovf;
    @(posedge clk) disable iff (!rst_n)
      (wr_valid && s_q.cnt == BUF_FULL) |=> (overflow && s_q.cnt <= BUF_FULL);
  endproperty
  a_buf_ovf: assert property (p_buf_ovf)
    else $error("write into full buffer not flagged");

  property p_buf_level;
    @(posedge clk) disable iff (!rst_n)
      (s_q.cnt <= BUF_FULL) && (wr_ready == (s_q.cnt != BUF_FULL));
  endproperty
  a_buf_level: assert property (p_buf_level)
    else $error("buffer level or ready out of range");

endmodule // pplm_buf
`default_nettype wire

// >>> design/pplm_ctrl.sv
// Seconds-pulse relay and slave transmit mode control, one per radio.
// Assumes mclk at 50 MHz, Avalon-MM register access, host pins async.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module pplm_ctrl
  import pplm_pkg::*;
#(
  parameter int CD_HIGH_CYCLES = CD_HIGH_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dtr_in,
  input wire logic rts_in,
  output logic cd_out,
  output logic cts_out,
  input wire logic host_tx_valid,
  input wire logic [7:0] host_tx_data,
  output logic host_tx_ready,
  output logic host_rx_valid,
  output logic [7:0] host_rx_data,
  input wire logic host_rx_ready,
  output logic air_tx_valid,
  output logic [7:0] air_tx_data,
  input wire logic air_tx_ready,
  input wire logic air_rx_valid,
  input wire logic [7:0] air_rx_data,
  output logic air_rx_ready,
  output logic air_pps_tx,
  input wire logic air_pps_rx,
  output logic [7:0] diag_level
);

  logic [1:0] rsync_q;
  logic rst_n;
  pplm_state_t s_q, s_d;
  logic [11:0] tx_level, rx_level;
  logic tx_ovf_p, rx_ovf_p;
  logic bus_wr, bus_rd_start, pps_en, dtr_rise, prx_rise;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  // Merge write data under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Programmed delay in ps; larger setting means shorter wait
  function automatic logic [27:0] dly_ps(input logic [7:0] setting);
    logic [27:0] t;
    t = 28'(DELAY_OFF - setting) * STEP_PS;
    if (t > PPS_CAP_PS) begin
      t = PPS_CAP_PS;
    end
    return t;
  endfunction

  function automatic logic [31:0] rd_word(input logic [4:0] addr,
                                         input pplm_state_t s,
                                         input logic [11:0] txl,
                                         input logic [11:0] rxl);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (addr)
      OFF_DELAY: r[7:0] = s.cfg.delay;
      OFF_DIAG: r[7:0] = s.cfg.diag;
      OFF_MODE: begin
        r[MODE_LSB +: 2] = s.cfg.mode;
        r[MODE_RTSCTS_BIT] = s.cfg.rts_cts_en;
        r[MODE_MASTER_BIT] = s.cfg.is_master;
      end
      OFF_STAT: begin
        r[STAT_TXOVF_BIT] = s.tx_ovf;
        r[STAT_RXOVF_BIT] = s.rx_ovf;
        r[STAT_PPSEN_BIT] = (s.cfg.delay != DELAY_OFF);
        r[STAT_CD_BIT] = s.cd;
        r[STAT_BURST_BIT] = s.bursting;
        r[STAT_TXLVL_LSB +: 12] = txl;
        r[STAT_RXLVL_LSB +: 12] = rxl;
      end
      OFF_BURST: r[11:0] = s.cfg.burst_thr;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb begin
    logic [31:0] m;
    logic clr_tx, clr_rx;
    m = 32'h0000_0000;
    clr_tx = 1'b0;
    clr_rx = 1'b0;
    s_d = s_q;

    // Avalon slave: waitrequest drops for one cycle per request
    bus_rd_start = (avs_read || avs_write) && s_q.waitreq;
    bus_wr = avs_write && !s_q.waitreq;
    s_d.waitreq = 1'b1;
    if (bus_rd_start) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = avs_read ? rd_word(avs_address, s_q, tx_level, rx_level)
                           : 32'h0000_0000;
    end
    if (bus_wr) begin
      case (avs_address)
        OFF_DELAY: begin
          m = be_merge({24'h0, s_q.cfg.delay}, avs_writedata, avs_byteenable);
          s_d.cfg.delay = m[7:0];
        end
        OFF_DIAG: begin
          m = be_merge({24'h0, s_q.cfg.diag}, avs_writedata, avs_byteenable);
          s_d.cfg.diag = (m[7:0] > DIAG_MAX) ? DIAG_MAX : m[7:0];
        end
        OFF_MODE: begin
          m = be_merge(rd_word(OFF_MODE, s_q, tx_level, rx_level),
                       avs_writedata, avs_byteenable);
          s_d.cfg.mode = m[MODE_LSB +: 2];
          s_d.cfg.rts_cts_en = m[MODE_RTSCTS_BIT];
          s_d.cfg.is_master = m[MODE_MASTER_BIT];
        end
        OFF_STAT: begin
          clr_tx = avs_byteenable[0] && avs_writedata[STAT_TXOVF_BIT];
          clr_rx = avs_byteenable[0] && avs_writedata[STAT_RXOVF_BIT];
        end
        OFF_BURST: begin
          m = be_merge({20'h0, s_q.cfg.burst_thr}, avs_writedata,
                       avs_byteenable);
          s_d.cfg.burst_thr = m[11:0];
        end
        default: m = 32'h0000_0000;
      endcase
    end

    // Sticky overflow flags, a new event beats the clear
    s_d.tx_ovf = (s_q.tx_ovf && !clr_tx) || tx_ovf_p;
    s_d.rx_ovf = (s_q.rx_ovf && !clr_rx) || rx_ovf_p;

    // Pin synchronisers, change taken when stages two and three agree
    s_d.dtr_sy = {s_q.dtr_sy[1:0], dtr_in};
    s_d.rts_sy = {s_q.rts_sy[1:0], rts_in};
    if (s_q.dtr_sy[1] == s_q.dtr_sy[2]) begin
      s_d.dtr_f = s_q.dtr_sy[2];
    end
    if (s_q.rts_sy[1] == s_q.rts_sy[2]) begin
      s_d.rts_f = s_q.rts_sy[2];
    end

    // Seconds pulse relay
    pps_en = (s_q.cfg.delay != DELAY_OFF);
    dtr_rise = s_d.dtr_f && !s_q.dtr_f;
    prx_rise = air_pps_rx && !s_q.prx_prev;
    s_d.prx_prev = air_pps_rx;
    s_d.pps_tx = pps_en && s_q.cfg.is_master && dtr_rise;
    case (s_q.pps_st)
      PPS_IDLE: begin
        s_d.cd = 1'b0;
        if (pps_en && !s_q.cfg.is_master && prx_rise) begin
          s_d.pps_st = PPS_WAIT;
          s_d.rem_ps = dly_ps(s_q.cfg.delay);
        end
      end
      PPS_WAIT: begin
        if (!pps_en) begin
          s_d.pps_st = PPS_IDLE;
        end else if (s_q.rem_ps <= CLK_PS) begin
          s_d.pps_st = PPS_HIGH;
          s_d.cd = 1'b1;
          s_d.hi_cnt = 17'h00000;
        end else begin
          s_d.rem_ps = s_q.rem_ps - CLK_PS;
        end
      end
      PPS_HIGH: begin
        s_d.hi_cnt = s_q.hi_cnt + 17'h00001;
        if (!pps_en || s_q.hi_cnt == 17'(CD_HIGH_CYCLES - 1)) begin
          s_d.pps_st = PPS_IDLE;
          s_d.cd = 1'b0;
        end
      end
      default: begin
        s_d.pps_st = PPS_IDLE;
        s_d.cd = 1'b0;
      end
    endcase

    // Burst collection: start at threshold, run until drained
    if (s_q.cfg.mode != TXM_BURST || s_q.cfg.is_master) begin
      s_d.bursting = 1'b0;
    end else if (!s_q.bursting) begin
      s_d.bursting = (tx_level != 12'h000) &&
                     (tx_level >= s_q.cfg.burst_thr);
    end else if (tx_level == 12'h000) begin
      s_d.bursting = 1'b0;
    end

    // Transmit gating per mode
    if (s_q.cfg.is_master) begin
      s_d.send_ok = s_q.cfg.rts_cts_en ? s_d.rts_f : 1'b1;
      s_d.cts = s_q.cfg.rts_cts_en ? (tx_level < CTS_LIMIT) : 1'b1;
    end else begin
      case (s_q.cfg.mode)
        TXM_DTR_LINK: begin
          s_d.send_ok = s_q.cfg.rts_cts_en ? s_d.rts_f
                                           : s_d.dtr_f;
          s_d.cts = s_q.cfg.rts_cts_en ? (tx_level < CTS_LIMIT) : 1'b1;
        end
        TXM_BURST: begin
          s_d.send_ok = s_d.bursting;
          s_d.cts = 1'b1;
        end
        default: begin
          s_d.send_ok = s_q.cfg.rts_cts_en ? s_d.rts_f : 1'b1;
          s_d.cts = s_q.cfg.rts_cts_en ? (tx_level < CTS_LIMIT) : 1'b1;
        end
      endcase
    end

    // Diagnostics level only acts on the master
    s_d.diag_lvl = s_q.cfg.is_master ? s_q.cfg.diag : 8'h00;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.cfg <= CFG_RST;
      s_q.waitreq <= 1'b1;
      s_q.cts <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  pplm_buf u_tx_buf (
    .clk(mclk),
    .rst_n(rst_n),
    .wr_valid(host_tx_valid),
    .wr_data(host_tx_data),
    .wr_ready(host_tx_ready),
    .rd_en(s_q.send_ok),
    .rd_valid(air_tx_valid),
    .rd_data(air_tx_data),
    .rd_ready(air_tx_ready),
    .level(tx_level),
    .overflow(tx_ovf_p)
  );

  pplm_buf u_rx_buf (
    .clk(mclk),
    .rst_n(rst_n),
    .wr_valid(air_rx_valid),
    .wr_data(air_rx_data),
    .wr_ready(air_rx_ready),
    .rd_en(1'b1),
    .rd_valid(host_rx_valid),
    .rd_data(host_rx_data),
    .rd_ready(host_rx_ready),
    .level(rx_level),
    .overflow(rx_ovf_p)
  );

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign cd_out = s_q.cd;
  assign cts_out = s_q.cts;
  assign air_pps_tx = s_q.pps_tx;
  assign diag_level = s_q.diag_lvl;

  // Helper: length of each CD high phase
  logic [16:0] chk_len_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chk_len_q <= 17'h00000;
    end else if (s_q.cd) begin
      chk_len_q <= chk_len_q + 17'h00001;
    end else begin
      chk_len_q <= 17'h00000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_slave_pulse_in;
    (s_q.pps_st == PPS_IDLE) && pps_en && !s_q.cfg.is_master && prx_rise;
  endsequence

  sequence s_cd_start;
    ##[1:1000] $rose(s_q.cd);
  endsequence

  property p_delay_reset;
    $rose(rst_n) |-> (s_q.cfg.delay == DELAY_RST) && !cd_out && !air_pps_tx;
  endproperty
  a_delay_reset: assert property (p_delay_reset)
    else $error("delay setting not 255 after reset");

  property p_pps_off;
    (s_q.cfg.delay == DELAY_OFF) && (s_q.pps_st != PPS_HIGH) |=>
      !s_q.cd && !air_pps_tx;
  endproperty
  a_pps_off: assert property (p_pps_off)
    else $error("pulse relayed while disabled");

  property p_master_relay;
    (pps_en && s_q.cfg.is_master && dtr_rise) |=> air_pps_tx;
  endproperty
  a_master_relay: assert property (p_master_relay)
    else $error("master DTR pulse not relayed");

  property p_step_load;
    s_slave_pulse_in |=> (s_q.rem_ps == dly_ps($past(s_q.cfg.delay)));
  endproperty
  a_step_load: assert property (p_step_load)
    else $error("delay load not steps of 542.534 ns");

  property p_step_order;
    s_slave_pulse_in and (s_q.cfg.delay != 8'h00) |=>
      (s_q.rem_ps <= dly_ps($past(s_q.cfg.delay) - 8'h01));
  endproperty
  a_step_order: assert property (p_step_order)
    else $error("larger delay value gave longer delay");

  property p_cd_width;
    $fell(s_q.cd) |-> ($past(chk_len_q) == 17'(CD_HIGH_CYCLES - 1)) ||
      !pps_en;
  endproperty
  a_cd_width: assert property (p_cd_width)
    else $error("CD pulse width wrong");

  property p_cd_bound;
    s_slave_pulse_in |-> s_cd_start or (##[1:1000] !pps_en);
  endproperty
  a_cd_bound: assert property (p_cd_bound)
    else $error("CD pulse later than 20 us");

  property p_diag_range;
    (s_q.cfg.diag <= DIAG_MAX) && (s_q.cfg.is_master || diag_level == 8'h00
      || $past(s_q.cfg.is_master));
  endproperty
  a_diag_range: assert property (p_diag_range)
    else $error("diagnostics setting out of range");

  property p_mode_immediate;
    !s_q.cfg.is_master && s_q.cfg.mode == TXM_IMMEDIATE &&
      !s_q.cfg.rts_cts_en |=> s_q.send_ok;
  endproperty
  a_mode_immediate: assert property (p_mode_immediate)
    else $error("mode 0 does not send at once");

  property p_dtr_gate;
    !s_q.cfg.is_master && s_q.cfg.mode == TXM_DTR_LINK &&
      !s_q.cfg.rts_cts_en |=> (s_q.send_ok == s_q.dtr_f);
  endproperty
  a_dtr_gate: assert property (p_dtr_gate)
    else $error("mode 1 send not gated by DTR");

  property p_rts_prio;
    !s_q.cfg.is_master && s_q.cfg.mode == TXM_DTR_LINK &&
      s_q.cfg.rts_cts_en |=> (s_q.send_ok == s_q.rts_f);
  endproperty
  a_rts_prio: assert property (p_rts_prio)
    else $error("RTS/CTS does not override DTR gating");

  property p_burst_hold;
    !s_q.cfg.is_master && s_q.cfg.mode == TXM_BURST && !s_q.bursting &&
      tx_level < s_q.cfg.burst_thr |=> !s_q.send_ok && s_q.cts;
  endproperty
  a_burst_hold: assert property (p_burst_hold)
    else $error("burst mode sent before threshold");

  property p_ovf_sticky;
    tx_ovf_p |=> s_q.tx_ovf;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow event lost");

endmodule // pplm_ctrl
`default_nettype wire

// >>> test/pplm_host_model.sv
// Host serial equipment model on the radio data port.
// Assumes the design's mclk; the bench asks for bytes and pulses.
`timescale 1ns/1ps
`default_nettype none
module pplm_host_model
  import pplm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic send_req,
  input wire logic [7:0] send_data,
  output logic send_done,
  input wire logic pps_go,
  input wire logic dtr_hold,
  input wire logic rts_lvl,
  input wire logic rx_stall,
  input wire logic cts_out,
  input wire logic host_tx_ready,
  output logic host_tx_valid,
  output logic [7:0] host_tx_data,
  output logic host_rx_ready,
  output logic dtr_in,
  output logic rts_in
);
  logic pend;
  logic [3:0] pw;
  assign dtr_in = dtr_hold | (pw != 4'h0);
  assign rts_in = rts_lvl;
  assign host_rx_ready = ~rx_stall;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
      pw <= 4'h0;
      host_tx_valid <= 1'b0;
      host_tx_data <= 8'h00;
      send_done <= 1'b0;
    end else begin
      send_done <= 1'b0;
      if (pps_go)
        pw <= 4'ha;
      else if (pw != 4'h0)
        pw <= pw - 4'h1;
      if (send_req)
        pend <= 1'b1;
      if (host_tx_valid && host_tx_ready) begin
        host_tx_valid <= 1'b0;
        host_tx_data <= ~host_tx_data;
        send_done <= 1'b1;
      end else if ((pend || send_req) && !host_tx_valid && cts_out) begin
        host_tx_valid <= 1'b1;
        host_tx_data <= send_data;
        pend <= 1'b0;
      end
    end
  end
endmodule // pplm_host_model
`default_nettype wire

// >>> test/tb_pplm_ctrl.sv
// Self-checking bench for the pulse relay and link mode control.
// Assumes the host model on the host port; the bench plays the radio.
`timescale 1ns/1ps
`default_nettype none
module tb_pplm_ctrl
  import pplm_pkg::*;
;
  localparam int CDH = 50;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, dtr_in, rts_in, cd_out, cts_out, send_done;
  logic host_tx_valid, host_tx_ready, host_rx_valid, host_rx_ready;
  logic [7:0] host_tx_data, host_rx_data, air_tx_data, diag_level;
  logic air_tx_valid, air_rx_ready, air_pps_tx;
  logic air_tx_ready = 1'b1;
  logic air_rx_valid = 1'b0;
  logic [7:0] air_rx_data = 8'h00;
  logic [7:0] send_data = 8'h00;
  logic air_pps_rx = 1'b0;
  logic send_req = 1'b0;
  logic pps_go = 1'b0;
  logic dtr_hold = 1'b0;
  logic rts_lvl = 1'b0;
  logic rx_stall = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  int tx_seen = 0;
  int dl[4] = '{254, 200, 1, 255};
  logic [7:0] q_tx[$];
  logic [7:0] q_rx[$];

  always #10 mclk = ~mclk;

  pplm_ctrl #(.CD_HIGH_CYCLES(CDH)) dut (.mclk(mclk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dtr_in(dtr_in), .rts_in(rts_in),
    .cd_out(cd_out), .cts_out(cts_out), .host_tx_valid(host_tx_valid),
    .host_tx_data(host_tx_data), .host_tx_ready(host_tx_ready),
    .host_rx_valid(host_rx_valid), .host_rx_data(host_rx_data),
    .host_rx_ready(host_rx_ready), .air_tx_valid(air_tx_valid),
    .air_tx_data(air_tx_data), .air_tx_ready(air_tx_ready),
    .air_rx_valid(air_rx_valid), .air_rx_data(air_rx_data),
    .air_rx_ready(air_rx_ready), .air_pps_tx(air_pps_tx),
    .air_pps_rx(air_pps_rx), .diag_level(diag_level));

  pplm_host_model u_host (.mclk(mclk), .rst_n(nrst), .send_req(send_req),
    .send_data(send_data), .send_done(send_done), .pps_go(pps_go),
    .dtr_hold(dtr_hold), .rts_lvl(rts_lvl), .rx_stall(rx_stall),
    .cts_out(cts_out), .host_tx_ready(host_tx_ready),
    .host_tx_valid(host_tx_valid), .host_tx_data(host_tx_data),
    .host_rx_ready(host_rx_ready), .dtr_in(dtr_in), .rts_in(rts_in));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Radio side: random stalls, in-order checks of both streams
  always @(posedge mclk) begin
    air_tx_ready <= 1'($urandom_range(1));
    rx_stall <= 1'($urandom_range(1));
    if (air_tx_valid === 1'b1 && air_tx_ready === 1'b1) begin
      chk("air_tx_data", {24'h0, q_tx.pop_front()}, {24'h0, air_tx_data});
      tx_seen++;
    end
    if (host_rx_valid === 1'b1 && host_rx_ready === 1'b1)
      chk("host_rx_data", {24'h0, q_rx.pop_front()}, {24'h0, host_rx_data});
  end

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    r = avs_readdata;
    if (n >= 50)
      chk("bus_answer", 32'h1, 32'h0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input string nm, input logic [4:0] a,
                    input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask

  task automatic send(input int k);
    int n;
    repeat (k) begin
      n = 0;
      send_data <= 8'($urandom);
      send_req <= 1'b1;
      @(posedge mclk);
      q_tx.push_back(send_data);
      send_req <= 1'b0;
      while (send_done !== 1'b1 && n < 200) begin
        @(posedge mclk);
        n++;
      end
    end
  endtask

  task automatic air_in(input logic [7:0] b);
    int n;
    n = 0;
    air_rx_valid <= 1'b1;
    air_rx_data <= b;
    q_rx.push_back(b);
    @(posedge mclk);
    while (air_rx_ready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    air_rx_valid <= 1'b0;
    air_rx_data <= ~b;
    @(posedge mclk);
  endtask

  task automatic wait_tx(input int e, input int lim);
    int n;
    n = 0;
    while (tx_seen < e && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk("air_tx_count", e, tx_seen);
  endtask

  task automatic relay(input logic e);
    int n;
    n = 0;
    pps_go <= 1'b1;
    @(posedge mclk);
    pps_go <= 1'b0;
    while (air_pps_tx !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    chk("pps_relay", {31'h0, e}, {31'h0, air_pps_tx});
    @(posedge mclk);
    chk("pps_one_cycle", 32'h0, {31'h0, air_pps_tx});
    repeat (20) @(posedge mclk);
  endtask

  task automatic slave_pulse(input int d);
    int n, h, e, g;
    n = 0;
    h = 0;
    e = (255 - d) * 542534;
    e = (d == 255) ? -1 : 1 + ((e > 19840000 ? 19840000 : e) + 19999) / 20000;
    wr(OFF_DELAY, d);
    air_pps_rx <= 1'b1;
    @(posedge mclk);
    while (cd_out !== 1'b1 && n < 1100) begin
      @(posedge mclk);
      n++;
    end
    air_pps_rx <= 1'b0;
    g = (n >= 1100) ? -1 : ((n > e - 5 && n < e + 5) ? e : n);
    chk("cd_delay", e, g);
    while (cd_out === 1'b1 && h < 200) begin
      @(posedge mclk);
      h++;
    end
    if (d != 255)
      chk("cd_width", CDH, h);
  endtask

  initial begin
    void'($urandom(32'h8ecf2257));
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    rd("delay_rst", OFF_DELAY, 32'h0ff);
    rd("diag_rst", OFF_DIAG, 32'h0);
    rd("mode_rst", OFF_MODE, 32'h0);
    rd("burst_rst", OFF_BURST, 32'h040);
    rd("unmapped", 5'h14, 32'h0);
    rd("stat_rst", OFF_STAT, 32'h0);
    chk("cts_idle", 32'h1, {31'h0, cts_out});
    $display("test reset done");
    foreach (dl[i])
      slave_pulse(dl[i]);
    $display("test slave pulse done");
    wr(OFF_MODE, 32'h8);
    relay(1'b0);
    wr(OFF_DELAY, 32'h0);
    relay(1'b1);
    wr(OFF_DIAG, 32'd200);
    rd("diag_clamp", OFF_DIAG, 32'h81);
    chk("diag_master", 32'h81, {24'h0, diag_level});
    wr(OFF_MODE, 32'h0);
    repeat (2) @(posedge mclk);
    chk("diag_slave", 32'h0, {24'h0, diag_level});
    $display("test master relay done");
    send(8);
    for (int i = 0; i < 4; i++)
      air_in(8'($urandom));
    wait_tx(8, 200);
    repeat (20) @(posedge mclk);
    chk("rx_drained", 32'h0, q_rx.size());
    $display("test immediate done");
    wr(OFF_MODE, 32'h1);
    send(3);
    repeat (20) @(posedge mclk);
    chk("dtr_gate", 32'd8, tx_seen);
    dtr_hold <= 1'b1;
    wait_tx(11, 200);
    dtr_hold <= 1'b0;
    wr(OFF_MODE, 32'h5);
    rts_lvl <= 1'b1;
    send(2);
    wait_tx(13, 200);
    $display("test dtr link done");
    wr(OFF_BURST, 32'h4);
    wr(OFF_MODE, 32'h6);
    rts_lvl <= 1'b0;
    send(3);
    repeat (20) @(posedge mclk);
    chk("burst_hold", 32'd13, tx_seen);
    chk("burst_cts", 32'h1, {31'h0, cts_out});
    rd("stat_hold", OFF_STAT, 32'h0000_0304);
    send(1);
    wait_tx(17, 200);
    $display("test burst done");
    wrap_up;
  end

  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    wrap_up;
  end
endmodule // tb_pplm_ctrl
`default_nettype wire
